// file: bld_slave.sv
// slave end: decodes transfer type and byte lanes, answers ack or fault
// assumes master keeps bus signals stable while the strobe is low
module bld_slave
  import bld_pkg::*;
#(
  parameter bit SUPPORT_BLOCK     = 1'b1,
  parameter bit SUPPORT_UNALIGNED = 1'b1,
  parameter bit SUPPORT_RMW       = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // bus side
  bld_bus_if.slave         bus,
  // user side
  output logic [31:0]      wrData,
  output logic [3:0]       byteEnable,
  output logic             wrStrobe,
  output logic             rdStrobe,
  output logic             faultSeen,
  input  wire logic [31:0] rdData
);
  typedef enum logic [2:0] {
    BLD_S_IDLE = 3'b001,
    BLD_S_WAIT = 3'b010,
    BLD_S_DONE = 3'b100
  } bld_sstate_t;

  bld_sstate_t state;
  bld_sstate_t next_state;
  logic [1:0]  delay;
  logic [1:0]  next_delay;
  logic        inBlock;
  logic        next_inBlock;
  logic [1:0]  nextByte;
  logic [1:0]  next_nextByte;
  logic        ack;
  logic        next_ack;
  logic        flt;
  logic        next_flt;
  logic        aack;
  logic        next_aack;
  logic [31:0] wrData_r;
  logic [31:0] next_wrData;
  logic [3:0]  be;
  logic [3:0]  next_be;
  logic        wrS;
  logic        next_wrS;
  logic        rdS;
  logic        next_rdS;
  logic [31:0] rdHold;
  logic [31:0] next_rdHold;

  // lane mask from strobe pattern; ok low when encoding is unsupported
  function automatic logic [4:0] decode(input logic lw, input logic a1,
                                        input logic u, input logic l);
    logic [3:0] m;
    logic       ok;
    m  = LANE_NONE;
    ok = 1'b1;
    unique case ({lw, a1, u, l})
      4'b1001: m = LANE_B0;
      4'b1010: m = LANE_B1;
      4'b1101: m = LANE_B2;
      4'b1110: m = LANE_B3;
      4'b1000: m = LANE_W01;
      4'b1100: m = LANE_W23;
      4'b0000: m = LANE_ALL;
      4'b0001: m = LANE_U012;
      4'b0010: m = LANE_U123;
      4'b0100: m = LANE_U12;
      default: ok = 1'b0;
    endcase
    return {ok, m};
  endfunction

  logic       strobe;
  logic       anyByte;
  logic       lwEff;
  logic [4:0] dec;
  logic       legalReq;
  logic       isUnal;
  logic       block_transfer_flag;
  logic       rmw;

  assign strobe  = ~bus.wideAddrStrobe_n;
  assign anyByte = ~bus.upperByteStrobe_n | ~bus.lowerByteStrobe_n;
  assign lwEff   = bus.legacyMode ? 1'b1 : bus.longWordFlag_n;
  assign block_transfer_flag     = ~bus.blockTransferFlag_n & ~bus.legacyMode;
  assign rmw     = ~bus.readModifyWriteFlag_n & ~bus.legacyMode;
  assign dec     = decode(lwEff, bus.wordSelectAddr,
                          bus.upperByteStrobe_n, bus.lowerByteStrobe_n);
  assign isUnal  = (dec[3:0] == LANE_U012) | (dec[3:0] == LANE_U123) |
                   (dec[3:0] == LANE_U12);

  always_comb begin
    legalReq = dec[4];
    // legacy limits to single byte or word
    if (bus.legacyMode && (dec[3:0] == LANE_ALL || isUnal))
      legalReq = 1'b0;
    if (isUnal && !SUPPORT_UNALIGNED)
      legalReq = 1'b0;
    if (block_transfer_flag && !SUPPORT_BLOCK)
      legalReq = 1'b0;
    if (rmw && !SUPPORT_RMW)
      legalReq = 1'b0;
    if (rmw && isUnal)
      legalReq = 1'b0;
  end

  always_comb begin
    next_state    = state;
    next_delay    = delay;
    next_inBlock  = inBlock;
    next_nextByte = nextByte;
    next_ack      = 1'b0;
    next_flt      = 1'b0;
    next_wrData   = wrData_r;
    next_be       = be;
    next_wrS      = 1'b0;
    next_rdS      = 1'b0;
    next_rdHold   = rdHold;
    next_aack     = strobe;
    unique case (state)
      BLD_S_IDLE: begin
        if (!strobe)
          next_inBlock = 1'b0;
        else if (anyByte) begin
          next_state = BLD_S_WAIT;
          next_delay = 2'(ACK_DELAY_CYC - 1);
          next_be    = dec[3:0];
          // block select valid on first only
          if (block_transfer_flag && inBlock && dec[3:0] != LANE_ALL) begin
            if (dec[3:0] == LANE_W01 || dec[3:0] == LANE_W23)
              next_be = nextByte[1] ? LANE_W23 : LANE_W01;
            else
              next_be = LANE_B0 >> nextByte;
          end
          // quad and unaligned on four lanes
          // byte and word on primary lanes
          if (dec[3:0] == LANE_ALL || isUnal)
            next_wrData = {bus.mPrimaryDataLanes, bus.mExtendedDataLanes};
          else
            next_wrData = {bus.mPrimaryDataLanes, bus.mPrimaryDataLanes};
          if (!legalReq)
            next_flt = 1'b1;
          else if (bus.readNotWrite)
            next_rdS = 1'b1;
          else
            next_wrS = 1'b1;
          if (!legalReq)
            next_state = BLD_S_DONE;
        end
      end
      BLD_S_WAIT: begin
        next_flt = 1'b0;
        if (delay == 2'h0) begin
          next_ack    = 1'b1;
          next_rdHold = rdData;
          next_state  = BLD_S_DONE;
          next_inBlock = block_transfer_flag;
          unique case (be)
            LANE_W01: next_nextByte = 2'h2;
            LANE_W23: next_nextByte = 2'h0;
            LANE_B0:  next_nextByte = 2'h1;
            LANE_B1:  next_nextByte = 2'h2;
            LANE_B2:  next_nextByte = 2'h3;
            LANE_B3:  next_nextByte = 2'h0;
            default:  next_nextByte = 2'h0;
          endcase
        end else
          next_delay = delay - 2'h1;
      end
      BLD_S_DONE: begin
        next_ack = ack;
        next_flt = flt | (~legalReq & anyByte & ~ack);
        if (!strobe || !anyByte) begin
          next_ack   = 1'b0;
          next_flt   = 1'b0;
          next_state = BLD_S_IDLE;
          if (!strobe)
            next_inBlock = 1'b0;
        end
      end
      default: next_state = BLD_S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state    <= BLD_S_IDLE;
      delay    <= 2'h0;
      inBlock  <= 1'b0;
      nextByte <= 2'h0;
      ack      <= 1'b0;
      flt      <= 1'b0;
      aack     <= 1'b0;
      wrData_r <= 32'h0000_0000;
      be       <= 4'h0;
      wrS      <= 1'b0;
      rdS      <= 1'b0;
      rdHold   <= 32'h0000_0000;
    end else begin
      state    <= next_state;
      delay    <= next_delay;
      inBlock  <= next_inBlock;
      nextByte <= next_nextByte;
      ack      <= next_ack;
      flt      <= next_flt;
      aack     <= next_aack;
      wrData_r <= next_wrData;
      be       <= next_be;
      wrS      <= next_wrS;
      rdS      <= next_rdS;
      rdHold   <= next_rdHold;
    end
  end

  assign bus.transferAck_n      = ~ack;
  assign bus.busFault_n         = ~flt;
  assign bus.addressAck_n       = ~aack;
  assign bus.sPrimaryDataLanes  = (be == LANE_ALL || be == LANE_U012 ||
                                   be == LANE_U123 || be == LANE_U12) ?
                                  rdHold[31:16] :
                                  (be == LANE_W23 || be == LANE_B2 ||
                                   be == LANE_B3) ? rdHold[15:0] :
                                  rdHold[31:16];
  assign bus.sExtendedDataLanes = rdHold[15:0];
  assign bus.sDataOe            = ack & bus.readNotWrite;
  assign wrData                 = wrData_r;
  assign byteEnable             = be;
  assign wrStrobe               = wrS;
  assign rdStrobe               = rdS;
  assign faultSeen              = flt;
endmodule

// file: bld_pkg.sv
// package: shared encodings and timing for the byte lane decoder ends
// assumes one 125 MHz clock shared by both ends
package bld_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned STROBE_MAX_NS  = 5100;
  localparam int unsigned FAULT_AFTER_NS = 5600;
  localparam int unsigned STROBE_MAX_CYC = STROBE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned FAULT_CYC      =
    (FAULT_AFTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_DELAY_CYC  = 2;

  // transfer kinds requested by the user side of the master
  typedef enum logic [2:0] {
    BLD_K_ADDR = 3'h0,
    BLD_K_BYTE = 3'h1,
    BLD_K_WORD = 3'h2,
    BLD_K_QUAD = 3'h3,
    BLD_K_U012 = 3'h4,
    BLD_K_U123 = 3'h5,
    BLD_K_U12  = 3'h6
  } bld_kind_t;

  localparam logic [3:0] LANE_NONE = 4'h0;
  localparam logic [3:0] LANE_B0   = 4'h8;
  localparam logic [3:0] LANE_B1   = 4'h4;
  localparam logic [3:0] LANE_B2   = 4'h2;
  localparam logic [3:0] LANE_B3   = 4'h1;
  localparam logic [3:0] LANE_W01  = 4'hC;
  localparam logic [3:0] LANE_W23  = 4'h3;
  localparam logic [3:0] LANE_ALL  = 4'hF;
  localparam logic [3:0] LANE_U012 = 4'hE;
  localparam logic [3:0] LANE_U123 = 4'h7;
  localparam logic [3:0] LANE_U12  = 4'h6;
endpackage

// file: bld_bus_if.sv
// interface: backplane signals between master and slave, strobes, flags and answers active low
// assumes a shared clock; strobes active low as on the bus
interface bld_bus_if;
  logic        wideAddrStrobe_n;
  logic        longWordFlag_n;
  logic        wordSelectAddr;
  logic        upperByteStrobe_n;
  logic        lowerByteStrobe_n;
  logic        blockTransferFlag_n;
  logic        readModifyWriteFlag_n;
  logic        readNotWrite;
  logic        legacyMode;
  logic [15:0] mPrimaryDataLanes;
  logic [15:0] mExtendedDataLanes;
  logic        mDataOe;
  logic [15:0] sPrimaryDataLanes;
  logic [15:0] sExtendedDataLanes;
  logic        sDataOe;
  logic        transferAck_n;
  logic        busFault_n;
  logic        addressAck_n;
  modport master (
    output wideAddrStrobe_n, longWordFlag_n, wordSelectAddr,
    output upperByteStrobe_n, lowerByteStrobe_n, blockTransferFlag_n,
    output readModifyWriteFlag_n, readNotWrite, legacyMode,
    output mPrimaryDataLanes, mExtendedDataLanes, mDataOe,
    input  sPrimaryDataLanes, sExtendedDataLanes, sDataOe,
    input  transferAck_n, busFault_n, addressAck_n
  );
  modport slave (
    input  wideAddrStrobe_n, longWordFlag_n, wordSelectAddr,
    input  upperByteStrobe_n, lowerByteStrobe_n, blockTransferFlag_n,
    input  readModifyWriteFlag_n, readNotWrite, legacyMode,
    input  mPrimaryDataLanes, mExtendedDataLanes, mDataOe,
    output sPrimaryDataLanes, sExtendedDataLanes, sDataOe,
    output transferAck_n, busFault_n, addressAck_n
  );
endinterface

// file: bld_master.sv
// master end: drives strobe patterns for a requested transfer kind
// assumes the slave answers with ack or fault before the bus timeout
module bld_master
  import bld_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // bus side
  bld_bus_if.master        bus,
  // user side
  input  wire logic        reqValid,
  input  wire bld_kind_t   reqKind,
  input  wire logic [1:0]  reqByte,
  input  wire logic        reqRead,
  input  wire logic        reqLegacy,
  input  wire logic [31:0] reqData,
  output logic             reqBusy,
  output logic             doneOk,
  output logic             doneFault,
  output logic [31:0]      rspData
);
  typedef enum logic [2:0] {
    BLD_M_IDLE = 3'b001,
    BLD_M_RUN  = 3'b010,
    BLD_M_END  = 3'b100
  } bld_mstate_t;

  bld_mstate_t state;
  bld_mstate_t next_state;
  logic [4:0]  pins;
  logic [4:0]  next_pins;
  logic [12:0] timer;
  logic [12:0] next_timer;
  logic        ok;
  logic        next_ok;
  logic        flt;
  logic        next_flt;
  logic [31:0] rsp;
  logic [31:0] next_rsp;
  logic [31:0] dat;
  logic [31:0] next_dat;
  logic        rd;
  logic        next_rd;
  logic        leg;
  logic        next_leg;

  // {strobe, long word, select, upper, lower} pattern per kind
  function automatic logic [4:0] encode(input bld_kind_t k,
                                        input logic [1:0] b);
    logic [4:0] p;
    p = 5'h1F;
    unique case (k)
      BLD_K_ADDR: p = 5'b01011;
      BLD_K_BYTE: p = {2'b01, b[1], b[0], ~b[0]};
      BLD_K_WORD: p = {2'b01, b[1], 2'b00};
      BLD_K_QUAD: p = 5'b00000;
      BLD_K_U012: p = 5'b00001;
      BLD_K_U123: p = 5'b00010;
      BLD_K_U12:  p = 5'b00100;
      default:    p = 5'h1F;
    endcase
    return p;
  endfunction

  always_comb begin
    next_state = state;
    next_pins  = pins;
    next_timer = timer;
    next_ok    = 1'b0;
    next_flt   = 1'b0;
    next_rsp   = rsp;
    next_dat   = dat;
    next_rd    = rd;
    next_leg   = leg;
    unique case (state)
      BLD_M_IDLE: begin
        // legacy sends no address only cycle
        // kind fixed before the cycle starts
        if (reqValid && !(reqLegacy && reqKind == BLD_K_ADDR)) begin
          next_pins  = encode(reqKind, reqByte);
          next_dat   = reqData;
          next_rd    = reqRead;
          next_leg   = reqLegacy;
          next_timer = 13'h0000;
          next_state = BLD_M_RUN;
        end
      end
      BLD_M_RUN: begin
        next_timer = timer + 13'h0001;
        if (pins[1:0] == 2'b11) begin
          next_ok    = 1'b1;
          next_state = BLD_M_END;
        end else if (!bus.transferAck_n) begin
          next_ok    = 1'b1;
          next_rsp   = {bus.sPrimaryDataLanes, bus.sExtendedDataLanes};
          // single byte or word on primary lanes
          if (pins[3] && pins[2])
            next_rsp = {16'h0000, bus.sPrimaryDataLanes};
          else if (pins[3])
            next_rsp = {bus.sPrimaryDataLanes, 16'h0000};
          next_state = BLD_M_END;
        // give up before the system timeout
        end else if (!bus.busFault_n ||
                     timer == 13'(STROBE_MAX_CYC - 1)) begin
          next_flt   = 1'b1;
          next_state = BLD_M_END;
        end
      end
      BLD_M_END: begin
        next_pins  = 5'h1F;
        if (bus.transferAck_n && bus.busFault_n)
          next_state = BLD_M_IDLE;
      end
      default: next_state = BLD_M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= BLD_M_IDLE;
      pins  <= 5'h1F;
      timer <= 13'h0000;
      ok    <= 1'b0;
      flt   <= 1'b0;
      rsp   <= 32'h0000_0000;
      dat   <= 32'h0000_0000;
      rd    <= 1'b1;
      leg   <= 1'b0;
    end else begin
      state <= next_state;
      pins  <= next_pins;
      timer <= next_timer;
      ok    <= next_ok;
      flt   <= next_flt;
      rsp   <= next_rsp;
      dat   <= next_dat;
      rd    <= next_rd;
      leg   <= next_leg;
    end
  end

  assign bus.wideAddrStrobe_n      = ~(state == BLD_M_RUN);
  assign bus.longWordFlag_n        = pins[3];
  assign bus.wordSelectAddr        = pins[2];
  assign bus.upperByteStrobe_n     = pins[1];
  assign bus.lowerByteStrobe_n     = pins[0];
  assign bus.blockTransferFlag_n   = 1'b1;
  assign bus.readModifyWriteFlag_n = 1'b1;
  assign bus.readNotWrite          = rd;
  assign bus.legacyMode            = leg;
  // upper word half on primary lanes, lower half for a byte or word with select set
  assign bus.mPrimaryDataLanes     = (pins[3] && pins[2]) ? dat[15:0] :
                                     dat[31:16];
  assign bus.mExtendedDataLanes    = dat[15:0];
  assign bus.mDataOe               = (state == BLD_M_RUN) & ~rd;
  assign reqBusy                   = (state != BLD_M_IDLE);
  assign doneOk                    = ok;
  assign doneFault                 = flt;
  assign rspData                   = rsp;
endmodule

// file: bld_bus_asserts.sv
// checker: timing relations on the bus between master and slave ends
// assumes the bench instantiates it beside the shared bus interface
module bld_bus_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // master driven
  input wire logic wideAddrStrobe_n,
  input wire logic longWordFlag_n,
  input wire logic upperByteStrobe_n,
  input wire logic lowerByteStrobe_n,
  input wire logic mDataOe,
  // slave driven
  input wire logic sDataOe,
  input wire logic transferAck_n,
  input wire logic busFault_n,
  input wire logic addressAck_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_ack_needs_strobe: assert property (
    $fell(transferAck_n) |->
      !$past(upperByteStrobe_n) || !$past(lowerByteStrobe_n))
    else $error("ack without byte strobe");
  a_addr_only_quiet: assert property (
    (!wideAddrStrobe_n && upperByteStrobe_n && lowerByteStrobe_n)
      |-> (transferAck_n && busFault_n)[*2])
    else $error("answer in address only cycle");
  a_answer_bound: assert property (
    (!wideAddrStrobe_n && !(upperByteStrobe_n && lowerByteStrobe_n))
      |-> ##[0:6] (!transferAck_n || !busFault_n))
    else $error("transfer not answered");
  a_one_answer: assert property (
    !(!transferAck_n && !busFault_n))
    else $error("ack and fault together");
  a_ack_stands: assert property (
    (!transferAck_n && !wideAddrStrobe_n
      && !(upperByteStrobe_n && lowerByteStrobe_n)) |=> !transferAck_n)
    else $error("ack dropped early");
  a_ack_after_take: assert property (
    $fell(transferAck_n) |-> $past(wideAddrStrobe_n, 2) == 1'b0)
    else $error("ack without address strobe");
  a_addr_ack_prompt: assert property (
    $fell(wideAddrStrobe_n) |-> ##[0:2] !addressAck_n)
    else $error("address ack missing");
  a_lane_owner: assert property (
    !(mDataOe && sDataOe))
    else $error("both ends drive data");

  c_ack: cover property ($fell(transferAck_n));
  c_quad: cover property ($fell(transferAck_n) && !longWordFlag_n);
  c_addr_only: cover property (
    !wideAddrStrobe_n && upperByteStrobe_n ##1 !addressAck_n);
endmodule

// file: tb.sv
// testbench: master and slave on one bus, a second slave on a bus
// that the bench drives with broken encodings
// assumes package, interface, both ends and checker compiled first
module tb
  import bld_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] WR_DATA = 32'h1122_3344;
  localparam logic [31:0] RD_DATA = 32'hA5B6_C7D8;
  typedef struct packed {
    bld_kind_t  kind;
    logic [1:0] start;
    logic       rd;
    logic       leg;
    logic [3:0] pat;
    logic [3:0] be;
  } bld_row_t;
  // kind, start, read, legacy, {lw, ws, upper, lower}, byte enables
  bld_row_t rows [15] = '{
    '{BLD_K_BYTE, 2'h0, 1'b0, 1'b0, 4'h9, 4'h8},
    '{BLD_K_BYTE, 2'h1, 1'b0, 1'b0, 4'hA, 4'h4},
    '{BLD_K_BYTE, 2'h2, 1'b0, 1'b0, 4'hD, 4'h2},
    '{BLD_K_BYTE, 2'h3, 1'b0, 1'b0, 4'hE, 4'h1},
    '{BLD_K_WORD, 2'h0, 1'b0, 1'b0, 4'h8, 4'hC},
    '{BLD_K_WORD, 2'h2, 1'b0, 1'b0, 4'hC, 4'h3},
    '{BLD_K_QUAD, 2'h0, 1'b0, 1'b0, 4'h0, 4'hF},
    '{BLD_K_U012, 2'h0, 1'b0, 1'b0, 4'h1, 4'hE},
    '{BLD_K_U123, 2'h0, 1'b0, 1'b0, 4'h2, 4'h7},
    '{BLD_K_U12,  2'h0, 1'b0, 1'b0, 4'h4, 4'h6},
    '{BLD_K_BYTE, 2'h3, 1'b1, 1'b0, 4'hE, 4'h1},
    '{BLD_K_QUAD, 2'h0, 1'b1, 1'b0, 4'h0, 4'hF},
    '{BLD_K_U12,  2'h0, 1'b1, 1'b0, 4'h4, 4'h6},
    '{BLD_K_WORD, 2'h2, 1'b1, 1'b1, 4'hC, 4'h3},
    '{BLD_K_BYTE, 2'h1, 1'b0, 1'b1, 4'hA, 4'h4}};
  logic        sys_clk, resetn, reqValid, reqRead, reqLegacy;
  bld_kind_t   reqKind;
  logic [1:0]  reqByte;
  logic [31:0] reqData, rspData, wrData, rdData;
  logic        reqBusy, doneOk, doneFault, wrStrobe, rdStrobe, faultB;
  logic [3:0]  byteEnable;
  int          nMismatch = 0;
  int          checksDone = 0;
  bld_bus_if busA ();
  bld_bus_if busB ();
  bld_master i_bld_master (.sys_clk(sys_clk), .resetn(resetn), .bus(busA),
    .reqValid(reqValid), .reqKind(reqKind), .reqByte(reqByte),
    .reqRead(reqRead), .reqLegacy(reqLegacy), .reqData(reqData),
    .reqBusy(reqBusy), .doneOk(doneOk), .doneFault(doneFault),
    .rspData(rspData));
  bld_slave i_bld_slave (.sys_clk(sys_clk), .resetn(resetn), .bus(busA),
    .wrData(wrData), .byteEnable(byteEnable), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .faultSeen(), .rdData(rdData));
  bld_slave #(.SUPPORT_BLOCK(1'b0), .SUPPORT_UNALIGNED(1'b0))
    i_bld_slave_b (.sys_clk(sys_clk), .resetn(resetn), .bus(busB),
    .wrData(), .byteEnable(), .wrStrobe(), .rdStrobe(), .faultSeen(faultB),
    .rdData(rdData));
  bld_bus_asserts i_bld_bus_asserts (.sys_clk(sys_clk), .resetn(resetn),
    .wideAddrStrobe_n(busA.wideAddrStrobe_n),
    .longWordFlag_n(busA.longWordFlag_n),
    .upperByteStrobe_n(busA.upperByteStrobe_n),
    .lowerByteStrobe_n(busA.lowerByteStrobe_n), .mDataOe(busA.mDataOe),
    .sDataOe(busA.sDataOe), .transferAck_n(busA.transferAck_n),
    .busFault_n(busA.busFault_n), .addressAck_n(busA.addressAck_n));

  always #4 sys_clk = ~sys_clk;

  function automatic logic [31:0] expand(input logic [3:0] be);
    expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  function automatic logic [31:0] laneMask(input bld_row_t r);
    laneMask = r.pat[3] ? {{8{~r.pat[1]}}, {8{~r.pat[0]}}, 16'h0000}
                        : expand(r.be);
  endfunction
  function automatic logic [31:0] laneData(input bld_row_t r);
    laneData = r.pat[3] ? {(r.pat[2] ? WR_DATA[15:0] : WR_DATA[31:16]),
                           16'h0000} : WR_DATA;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic waitIdle;
    int i;
    for (i = 0; i < 20 && reqBusy !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (reqBusy !== 1'b0) begin
      chk("busy timeout", 32'(reqBusy), 32'h0000_0000);
      endOfTest();
    end
  endtask
  task automatic runReq(input bld_row_t r);
    logic [3:0]  pat;
    logic [31:0] lanes;
    logic        seen, ok, flt;
    int          i, nWr, nRd;
    seen = 1'b0;
    ok = 1'b0;
    flt = 1'b0;
    nWr = 0;
    nRd = 0;
    @(posedge sys_clk);
    reqValid  <= 1'b1;
    reqKind   <= r.kind;
    reqByte   <= r.start;
    reqRead   <= r.rd;
    reqLegacy <= r.leg;
    for (i = 0; i < 60 && !(ok || flt); i++) begin
      @(posedge sys_clk);
      reqValid <= 1'b0;
      #1;
      if (!seen && !busA.wideAddrStrobe_n
          && !(busA.upperByteStrobe_n && busA.lowerByteStrobe_n)) begin
        seen = 1'b1;
        pat = {busA.longWordFlag_n, busA.wordSelectAddr,
               busA.upperByteStrobe_n, busA.lowerByteStrobe_n};
        lanes = {busA.mPrimaryDataLanes, busA.mExtendedDataLanes};
      end
      nWr += int'(wrStrobe);
      nRd += int'(rdStrobe);
      ok = doneOk;
      flt = doneFault;
    end
    if (!(ok || flt)) begin
      chk("answer timeout", 32'({ok, flt}), 32'h0000_0002);
      endOfTest();
    end
    waitIdle();
    chk("done ok", 32'({ok, flt}), 32'h0000_0002);
    chk("strobe pattern", 32'(pat[2:0]), 32'(r.pat[2:0]));
    if (!r.leg) chk("long word", 32'(pat[3]), 32'(r.pat[3]));
    chk("byte enable", 32'(byteEnable), 32'(r.be));
    chk("pulses", 32'({nWr[3:0], nRd[3:0]}), r.rd ? 32'h01 : 32'h10);
    if (r.rd) begin
      chk("read data", rspData & expand(r.be), RD_DATA & expand(r.be));
    end else begin
      chk("lanes", lanes & laneMask(r), laneData(r) & laneMask(r));
      chk("write data", wrData & expand(r.be), WR_DATA & expand(r.be));
    end
  endtask
  task automatic addrOnly(input logic leg);
    logic ans, adr, wide;
    int   i;
    ans = 1'b0;
    adr = 1'b0;
    wide = 1'b0;
    @(posedge sys_clk);
    reqValid  <= 1'b1;
    reqKind   <= BLD_K_ADDR;
    reqLegacy <= leg;
    for (i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      reqValid <= 1'b0;
      #1;
      ans |= !busA.transferAck_n || !busA.busFault_n || doneFault;
      adr |= !busA.addressAck_n;
      wide |= !busA.wideAddrStrobe_n;
    end
    waitIdle();
    chk("addr only answer", 32'(ans), 32'h0000_0000);
    chk("addr only ack", 32'(adr), 32'(!leg));
    chk("addr only strobe", 32'(wide), 32'(!leg));
  endtask
  // code is {block, long word, select, upper, lower}; exp is {ack, fault}
  task automatic rogue(input logic [4:0] code, input logic [1:0] exp);
    logic [1:0] ans;
    logic       fs;
    int         i;
    ans = 2'b00;
    fs = 1'b0;
    @(posedge sys_clk);
    busB.blockTransferFlag_n <= code[4];
    busB.longWordFlag_n      <= code[3];
    busB.wordSelectAddr      <= code[2];
    busB.upperByteStrobe_n   <= code[1];
    busB.lowerByteStrobe_n   <= code[0];
    busB.wideAddrStrobe_n    <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      #1;
      ans |= {!busB.transferAck_n, !busB.busFault_n};
      fs |= faultB;
    end
    @(posedge sys_clk);
    busB.wideAddrStrobe_n    <= 1'b1;
    busB.upperByteStrobe_n   <= 1'b1;
    busB.lowerByteStrobe_n   <= 1'b1;
    busB.blockTransferFlag_n <= 1'b1;
    for (i = 0; i < 10 && !(busB.transferAck_n && busB.busFault_n); i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (!(busB.transferAck_n && busB.busFault_n)) begin
      chk("rogue release", 32'({busB.transferAck_n, busB.busFault_n}),
          32'h0000_0003);
      endOfTest();
    end
    chk("rogue answer", 32'(ans), 32'(exp));
    chk("rogue fault flag", 32'(fs), 32'(exp[0]));
  endtask

  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    reqValid = 1'b0;
    reqKind = BLD_K_BYTE;
    reqByte = 2'h0;
    reqRead = 1'b0;
    reqLegacy = 1'b0;
    reqData = WR_DATA;
    rdData = RD_DATA;
    busB.wideAddrStrobe_n = 1'b1;
    busB.longWordFlag_n = 1'b1;
    busB.wordSelectAddr = 1'b0;
    busB.upperByteStrobe_n = 1'b1;
    busB.lowerByteStrobe_n = 1'b1;
    busB.blockTransferFlag_n = 1'b1;
    busB.readModifyWriteFlag_n = 1'b1;
    busB.readNotWrite = 1'b0;
    busB.legacyMode = 1'b0;
    busB.mPrimaryDataLanes = WR_DATA[31:16];
    busB.mExtendedDataLanes = WR_DATA[15:0];
    busB.mDataOe = 1'b1;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (rows[k]) runReq(rows[k]);
    addrOnly(1'b0);
    addrOnly(1'b1);
    rogue(5'h11, 2'h1);
    rogue(5'h15, 2'h1);
    rogue(5'h16, 2'h1);
    rogue(5'h09, 2'h1);
    rogue(5'h19, 2'h2);
    rogue(5'h13, 2'h0);
    // reset in mid transfer
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqKind  <= BLD_K_QUAD;
    reqRead  <= 1'b0;
    reqLegacy <= 1'b0;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b0;
    #1;
    chk("reset strobes", 32'({busA.wideAddrStrobe_n, busA.upperByteStrobe_n,
        busA.lowerByteStrobe_n}), 32'h0000_0007);
    chk("reset answers", 32'({busA.transferAck_n, busA.busFault_n,
        reqBusy, doneOk}), 32'h0000_000C);
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    runReq(rows[6]);
    endOfTest();
  end
endmodule
